// ===== line_signal_loss_and_alarm_detect.sv
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
// Summary of operation
// (R1) N low intervals declare loss, pin, interrupt
// (R2) clear after M good intervals from pulse
// (R3) loss clear drives indicator pin low
// (R4) fixed 800 mVpp declare, 200 mVpp hysteresis
// (R5) equalizer on: field selects Q, plus 4dB
// (R6) hardware mode forces fixed thresholds
// (R7) counts chosen by criteria and standard
// (R8) criteria bit picks N; standard alone picks M
// (R9) T1 declare after 175 or 1544
// (R10) E1 declare after 32 or 2048
// (R11) T1 clear: 128 window, under 100 zeros
// (R12) E1 clear: 32 window, under 16 zeros
// (R13) rx fill: all ones on master clock
// (R14) tx fill: all ones on master clock
// (R15) loss indication active in all loopbacks
// (R16) alarm detect only with clock recovery on
// (R17) criteria bit resets to zero
// (R18) E1 alarm set: two blocks under 3 zeros
// (R19) E1 alarm clear: two blocks 3+ zeros
// (R20) T1 alarm set: 8192 block under 9 zeros
// (R21) T1 alarm clear: 8192 block 9+ zeros
// (R22) one level comparison per pulse interval
// (R23) alternate E1 criteria use same alarm test
module line_signal_loss_and_alarm_detect
  import line_loss_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire line_pins_s line_pins,
  output logic signal_loss_pin,
  output logic loss_irq,
  output logic rx_recovered_clock_out,
  output logic [1:0] rx_rail_data_out,
  output logic [1:0] tx_line_output,
  output threshold_s level_threshold
);

  // ******************************************************
  // pin synchronisers
  // ******************************************************
  localparam int PIN_W = $bits(line_pins_s);
  logic [PIN_W-1:0] sync1;
  logic [PIN_W-1:0] sync2;
  line_pins_s pins_s;
  logic rclk_d;
  logic mclk_d;

  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++)
    begin : g_sync
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
        end
        else
        begin
          sync1[gi] <= line_pins[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  assign pins_s = line_pins_s'(sync2);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rclk_d <= 1'b0;
      mclk_d <= 1'b0;
    end
    else
    begin
      rclk_d <= pins_s.rclk;
      mclk_d <= pins_s.mclk;
    end
  end

  // one strobe per received pulse interval
  wire bit_tick = pins_s.rclk & ~rclk_d;
  wire mclk_tick = pins_s.mclk & ~mclk_d;
  wire lvl = pins_s.level_above;
  wire mark = pins_s.mark;

  // ******************************************************
  // control decode
  // ******************************************************
  logic [31:0] ctrl;
  logic los;
  logic ais;
  logic loss_event;

  wire crit = ctrl[CRIT_BIT];
  wire std_t1 = ctrl[STD_BIT];
  wire rx_fill_en = ctrl[RX_FILL_BIT];
  wire tx_fill_en = ctrl[TX_FILL_BIT];
  wire cdr_en = ctrl[CDR_BIT];
  wire irq_en = ctrl[IRQ_EN_BIT];
  wire [4:0] level_code = ctrl[LEVEL_LSB+4:LEVEL_LSB];
  // a hardware-mode strap overrides the equalizer bit
  wire eq_active = ctrl[EQ_BIT] & ~pins_s.hw_mode; // R6

  wire [11:0] n_count = std_t1 ? (crit ? N_T1_CRIT1 : N_T1_CRIT0) // R7 R8 R9
                               : (crit ? N_E1_CRIT1 : N_E1_CRIT0); // R10
  wire [7:0] m_count = std_t1 ? M_T1 : M_E1; // R11 R12
  wire [6:0] zrun_limit = std_t1 ? ZRUN_T1 : ZRUN_E1; // R11 R12
  wire [7:0] marks_min = m_count >> DENSITY_SHIFT; // R2

  // ******************************************************
  // loss declare
  // ******************************************************
  logic [11:0] low_run;
  wire declare_hit = bit_tick & ~los & ~lvl
                     & (low_run == n_count - 12'h001); // R1 R22
  wire [11:0] next_low_run = (los | lvl) ? 12'h000
                             : low_run + 12'h001; // R1

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      low_run <= 12'h000;
    else if (bit_tick)
      low_run <= next_low_run;
  end

  // ******************************************************
  // loss clear
  // ******************************************************
  clear_state_e clr_state;
  logic [7:0] win_cnt;
  logic [7:0] marks;
  logic [6:0] zrun;
  wire [6:0] next_zrun = mark ? 7'h00 : zrun + 7'h01;
  wire [7:0] next_marks = marks + {7'h00, mark};
  wire run_bad = ~lvl | (next_zrun >= zrun_limit); // R11 R12 R22
  wire win_end = win_cnt == m_count - 8'h01;
  wire start_hit = bit_tick & los & mark & lvl
                   & (clr_state == CLR_WAIT); // R2
  wire clear_hit = bit_tick & (clr_state == CLR_COUNT) & ~run_bad
                   & win_end & (next_marks >= marks_min); // R2

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      clr_state <= CLR_WAIT;
      win_cnt <= 8'h00;
      marks <= 8'h00;
      zrun <= 7'h00;
    end
    else
    begin
      case (clr_state)
        CLR_WAIT:
        begin
          if (start_hit)
          begin
            clr_state <= CLR_COUNT;
            win_cnt <= 8'h01;
            marks <= 8'h01;
            zrun <= 7'h00;
          end
        end
        CLR_COUNT:
        begin
          // any failure restarts the wait for a fresh pulse
          if (!los)
            clr_state <= CLR_WAIT;
          else if (bit_tick)
          begin
            if (run_bad || win_end)
              clr_state <= CLR_WAIT; // R2
            win_cnt <= win_cnt + 8'h01;
            marks <= next_marks;
            zrun <= next_zrun;
          end
        end
        default:
          clr_state <= CLR_WAIT;
      endcase
    end
  end

  // the detector is not gated by any loopback setting
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      los <= 1'b0;
    else if (declare_hit)
      los <= 1'b1; // R1 R15
    else if (clear_hit)
      los <= 1'b0; // R2 R3
  end

  assign signal_loss_pin = los; // R1 R3

  // ******************************************************
  // comparator threshold
  // ******************************************************
  wire [4:0] code_c = (level_code > LEVEL_CODE_MAX) ? LEVEL_CODE_MAX
                      : level_code;
  wire [5:0] q_db = Q_BASE_DB + {code_c, 1'b0}; // R5
  threshold_s next_threshold;

  always_comb
  begin
    next_threshold.fixed = ~eq_active; // R6
    next_threshold.clear_level = los; // R22
    next_threshold.mvpp = los ? FIXED_DECLARE_MVPP + HYST_MVPP
                          : FIXED_DECLARE_MVPP; // R4
    next_threshold.atten_db = los ? q_db - HYST_DB : q_db; // R5
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      level_threshold <= '0;
    else
      level_threshold <= next_threshold;
  end

  // ******************************************************
  // alarm indication detect
  // ******************************************************
  logic [13:0] blk_cnt;
  logic [3:0] zeros;
  logic prev_low;
  wire [13:0] blk_len = std_t1 ? AIS_T1_BLOCK : AIS_E1_BLOCK;
  wire [3:0] zeros_min = std_t1 ? AIS_T1_ZEROS : AIS_E1_ZEROS;
  // saturating: only the comparison against a small limit matters
  wire [3:0] next_zeros = (!mark && zeros != 4'hF) ? zeros + 4'h1
                          : zeros;
  wire blk_end = bit_tick & (blk_cnt == blk_len - 14'h0001);
  wire blk_low = next_zeros < zeros_min;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !cdr_en)
    begin
      blk_cnt <= 14'h0000; // R16
      zeros <= 4'h0;
      prev_low <= 1'b0;
      ais <= 1'b0;
    end
    else if (blk_end)
    begin
      blk_cnt <= 14'h0000;
      zeros <= 4'h0;
      prev_low <= blk_low;
      if (std_t1)
        ais <= blk_low; // R20 R21
      else if (blk_low && prev_low)
        ais <= 1'b1; // R18 R23
      else if (!blk_low && !prev_low)
        ais <= 1'b0; // R19 R23
    end
    else if (bit_tick)
    begin
      blk_cnt <= blk_cnt + 14'h0001;
      zeros <= next_zeros;
    end
  end

  // ******************************************************
  // all-ones fill on master clock
  // ******************************************************
  logic fill_phase;
  wire rx_fill_on = los & rx_fill_en;
  wire tx_fill_on = los & tx_fill_en;
  // alternate rails so the fill is a legal bipolar all-ones stream
  wire [1:0] fill_rails = fill_phase ? 2'b10 : 2'b01;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      fill_phase <= 1'b0;
    else if (mclk_tick)
      fill_phase <= ~fill_phase;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_rail_data_out <= 2'b00;
      rx_recovered_clock_out <= 1'b0;
      tx_line_output <= 2'b00;
    end
    else
    begin
      rx_rail_data_out <= rx_fill_on ? fill_rails : pins_s.rx_rail; // R13
      rx_recovered_clock_out <= rx_fill_on ? pins_s.mclk
                                : pins_s.rclk; // R13
      tx_line_output <= tx_fill_on ? fill_rails : pins_s.tx_data; // R14
    end
  end

  // ******************************************************
  // register slave
  // ******************************************************
  wire wr_go = awvalid & wvalid & ~bvalid;
  wire wr_ctrl = wr_go & (awaddr == CTRL_OFFSET);
  wire wr_event = wr_go & (awaddr == EVENT_OFFSET);
  wire wr_ok = wr_go & (awaddr == CTRL_OFFSET || awaddr == STATUS_OFFSET
                        || awaddr == EVENT_OFFSET);
  wire evt_clr = wr_event & wstrb[0] & wdata[LOSS_EVT_BIT];
  wire rd_go = arvalid & arready;
  wire rd_ok = araddr == CTRL_OFFSET || araddr == STATUS_OFFSET
               || araddr == EVENT_OFFSET;
  wire [31:0] status_w = {30'h0, ais, los}; // R16
  wire [31:0] rd_mux = (araddr == CTRL_OFFSET) ? ctrl
                       : (araddr == STATUS_OFFSET) ? status_w
                       : (araddr == EVENT_OFFSET) ? {31'h0, loss_event}
                       : 32'h0000_0000;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        r[b*8 +: 8] = new_v[b*8 +: 8];
    return r & CTRL_MASK;
  endfunction

  assign awready = wr_go;
  assign wready = wr_go;
  assign arready = ~rvalid;
  assign loss_irq = loss_event & irq_en; // R1

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl <= CTRL_RESET; // R17
    else if (wr_ctrl)
      ctrl <= merge_bytes(ctrl, wdata, wstrb);
  end

  // a new declare in the same cycle as a clear keeps the flag
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      loss_event <= 1'b0;
    else
      loss_event <= declare_hit | (loss_event & ~evt_clr); // R1
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid <= 1'b1;
      bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end
    else if (rd_go)
    begin
      rvalid <= 1'b1;
      rdata <= rd_mux;
      rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  // ******************************************************
  // checks
  // ******************************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_fill_rx;
    rx_fill_on ##1 rx_fill_on;
  endsequence

  sequence s_fill_tx;
    tx_fill_on ##1 tx_fill_on;
  endsequence

  chk_declare_count: assert property ( // R1
    $rose(los) |-> $past(low_run) == n_count - 12'h001 && !$past(lvl))
    else $error("loss declared at wrong count");

  chk_clear_window: assert property ( // R2
    $fell(los) |-> $past(win_cnt) == m_count - 8'h01 && $past(lvl))
    else $error("loss cleared outside window end");

  chk_irq_on_loss: assert property ( // R1
    ($rose(los) && irq_en) |-> loss_irq && signal_loss_pin)
    else $error("loss interrupt missing");

  chk_hw_fixed: assert property ( // R6
    pins_s.hw_mode |=> level_threshold.fixed)
    else $error("hardware mode not fixed threshold");

  chk_fixed_hyst: assert property ( // R4
    ($rose(los) && !eq_active) |=>
      level_threshold.mvpp == $past(level_threshold.mvpp) + HYST_MVPP)
    else $error("fixed hysteresis wrong");

  chk_eq_hyst: assert property ( // R5
    ($rose(los) && eq_active && $stable(level_code)) |=>
      level_threshold.atten_db == $past(level_threshold.atten_db) - HYST_DB)
    else $error("equalizer hysteresis wrong");

  chk_rx_fill: assert property ( // R13
    s_fill_rx |-> ^rx_rail_data_out)
    else $error("rx fill not all ones");

  chk_tx_fill: assert property ( // R14
    s_fill_tx |-> ^tx_line_output)
    else $error("tx fill not all ones");

  chk_ais_cdr: assert property ( // R16
    !cdr_en |=> !ais)
    else $error("alarm active without clock recovery");

  chk_ais_t1_set: assert property ( // R20
    ($rose(ais) && std_t1) |-> $past(next_zeros) < AIS_T1_ZEROS)
    else $error("t1 alarm set with enough zeros");

  chk_ais_e1_pair: assert property ( // R18
    ($rose(ais) && !std_t1) |-> $past(prev_low) && $past(blk_low))
    else $error("e1 alarm set without two low blocks");

endmodule

// ===== line_loss_pkg.sv
package line_loss_pkg;

  // ******************************************************
  // register map
  // ******************************************************
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] EVENT_OFFSET = 8'h08;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0000_1F7F;
  localparam int CRIT_BIT = 0;
  localparam int STD_BIT = 1;
  localparam int RX_FILL_BIT = 2;
  localparam int TX_FILL_BIT = 3;
  localparam int EQ_BIT = 4;
  localparam int CDR_BIT = 5;
  localparam int IRQ_EN_BIT = 6;
  localparam int LEVEL_LSB = 8;
  localparam int LOSS_STAT_BIT = 0;
  localparam int AIS_STAT_BIT = 1;
  localparam int LOSS_EVT_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ******************************************************
  // detection counts, in pulse intervals
  // ******************************************************
  localparam logic [11:0] N_T1_CRIT0 = 12'h0AF;
  localparam logic [11:0] N_T1_CRIT1 = 12'h608;
  localparam logic [11:0] N_E1_CRIT0 = 12'h020;
  localparam logic [11:0] N_E1_CRIT1 = 12'h800;
  localparam logic [7:0] M_T1 = 8'h80;
  localparam logic [7:0] M_E1 = 8'h20;
  localparam logic [6:0] ZRUN_T1 = 7'h64;
  localparam logic [6:0] ZRUN_E1 = 7'h10;
  localparam int DENSITY_SHIFT = 3;
  localparam logic [13:0] AIS_T1_BLOCK = 14'h2000;
  localparam logic [13:0] AIS_E1_BLOCK = 14'h0200;
  localparam logic [3:0] AIS_T1_ZEROS = 4'h9;
  localparam logic [3:0] AIS_E1_ZEROS = 4'h3;

  // ******************************************************
  // level thresholds
  // ******************************************************
  localparam logic [10:0] FIXED_DECLARE_MVPP = 11'h320;
  localparam logic [10:0] HYST_MVPP = 11'h0C8;
  localparam logic [5:0] Q_BASE_DB = 6'h04;
  localparam logic [5:0] HYST_DB = 6'h04;
  localparam logic [4:0] LEVEL_CODE_MAX = 5'h0A;

  typedef enum logic [1:0] {
    CLR_WAIT = 2'b01,
    CLR_COUNT = 2'b10
  } clear_state_e;

  // pins from the analog front end and clock recovery
  typedef struct packed {
    logic rclk;
    logic mclk;
    logic mark;
    logic level_above;
    logic [1:0] rx_rail;
    logic [1:0] tx_data;
    logic hw_mode;
  } line_pins_s;

  // threshold handed to the front end comparator
  typedef struct packed {
    logic fixed;
    logic clear_level;
    logic [10:0] mvpp;
    logic [5:0] atten_db;
  } threshold_s;

endpackage

// ===== line_front_end_model.sv
`timescale 1ns/100ps
module line_front_end_model
  import line_loss_pkg::*;
(
  input wire logic mark_req,
  input wire logic [10:0] amp,
  input wire logic [1:0] tx_req,
  input wire logic hw_req,
  input wire threshold_s threshold,
  output line_pins_s pins
);
  logic rclk = 1'h0;
  logic mclk = 1'h0;
  logic mark_q = 1'h0;
  logic above_q = 1'h0;
  // both clocks free-run; rclk is offset from the bus clock, mclk edges fall on bus clock edges
  initial
  begin
    #1.3;
    forever #16 rclk = ~rclk;
  end
  initial
  begin
    forever #18 mclk = ~mclk;
  end
  // amp is mVpp in fixed mode, dB below nominal with the equalizer
  always @(negedge rclk)
  begin
    mark_q <= mark_req;
    above_q <= threshold.fixed ? (amp > threshold.mvpp)
      : (amp < {5'h00, threshold.atten_db});
  end
  assign pins = '{rclk: rclk, mclk: mclk, mark: mark_q, level_above: above_q,
    rx_rail: {mark_q, 1'h0}, tx_data: tx_req, hw_mode: hw_req};
endmodule

// ===== testbench.sv
`timescale 1ns/100ps
module testbench
  import line_loss_pkg::*;
;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic mark_req = 1'h0;
  logic [10:0] amp = 11'h000;
  logic [1:0] tx_req = 2'h3;
  logic hw_req = 1'h0;
  line_pins_s pins;
  logic loss, irq, rx_clk;
  logic [1:0] rx_out, tx_out;
  threshold_s thr;
  int fail_count = 0;
  int tests_run = 0;
  logic [31:0] rd;
  logic [1:0] rsp;
  logic [31:0] c;
  int n_tab[4] = '{32, 2048, 175, 1544};
  int m_tab[4] = '{32, 32, 128, 128};

  initial
  begin
    forever #2 aclk = ~aclk;
  end

  line_front_end_model far_end (.mark_req(mark_req), .amp(amp),
    .tx_req(tx_req), .hw_req(hw_req), .threshold(thr), .pins(pins));

  line_signal_loss_and_alarm_detect dut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .line_pins(pins),
    .signal_loss_pin(loss), .loss_irq(irq), .rx_recovered_clock_out(rx_clk),
    .rx_rail_data_out(rx_out), .tx_line_output(tx_out),
    .level_threshold(thr));

  // ****************************************
  // bus and line tasks
  // ****************************************
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do @(posedge aclk); while (awready !== 1'h1 || wready !== 1'h1);
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    do @(posedge aclk); while (bvalid !== 1'h1);
    rsp = bresp;
    bready <= 1'h0;
    repeat (2) @(posedge aclk);
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge aclk); while (rvalid !== 1'h1);
    rd = rdata;
    rsp = rresp;
    rready <= 1'h0;
  endtask

  // n pulse intervals carrying the given mark and amplitude
  task automatic ticks(input int n, input logic m, input logic [10:0] a);
    @(posedge pins.rclk);
    mark_req = m;
    amp = a;
    repeat (n) @(posedge pins.rclk);
    repeat (6) @(posedge aclk);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    // about 62k cycles of tests; stay under 90k cycles
    #360000;
    fail_count++;
    final_report();
  end

  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    rd_reg(CTRL_OFFSET);
    check("ctrl reset", rd, CTRL_RESET);
    rd_reg(STATUS_OFFSET);
    check("status reset", rd, 32'h0000_0000);
    wr(CTRL_OFFSET, 32'hFFFF_FFFF);
    rd_reg(CTRL_OFFSET);
    check("ctrl mask", rd, CTRL_MASK);
    wr(STATUS_OFFSET, 32'h0000_0000);
    check("status write resp", rsp, RESP_OKAY);
    wr(8'h0C, 32'h0000_0001);
    check("unmapped write resp", rsp, RESP_SLVERR);
    rd_reg(8'h0C);
    check("unmapped read data", rd, 32'h0000_0000);
    check("unmapped read resp", rsp, RESP_SLVERR);
    $display("test registers done");
    for (int i = 0; i < 4; i++)
    begin
      c = 32'h0000_0000;
      c[CRIT_BIT] = i[0];
      c[STD_BIT] = i[1];
      c[IRQ_EN_BIT] = 1'h1;
      wr(CTRL_OFFSET, c);
      ticks(40, 1'h1, 11'h5DC);
      wr(EVENT_OFFSET, 32'h0000_0001);
      ticks(n_tab[i] - 1, 1'h0, 11'h000);
      check("loss early", loss, 32'h0000_0000);
      ticks(1, 1'h0, 11'h000);
      check("loss pin", loss, 32'h0000_0001);
      check("loss irq", irq, 32'h0000_0001);
      rd_reg(STATUS_OFFSET);
      check("loss status", rd[LOSS_STAT_BIT], 32'h0000_0001);
      wr(EVENT_OFFSET, 32'h0000_0001);
      check("irq cleared", irq, 32'h0000_0000);
      ticks(m_tab[i] - 1, 1'h1, 11'h5DC);
      check("loss held", loss, 32'h0000_0001);
      ticks(1, 1'h1, 11'h5DC);
      check("loss cleared", loss, 32'h0000_0000);
      $display("test criteria %0d done", i);
    end
    wr(CTRL_OFFSET, 32'h0000_0000);
    ticks(40, 1'h1, 11'h384);
    check("no declare 900", loss, 32'h0000_0000);
    check("fixed mode", thr.fixed, 32'h0000_0001);
    check("declare level", thr.mvpp, 32'h0000_0320);
    ticks(32, 1'h0, 11'h000);
    check("declared", loss, 32'h0000_0001);
    check("clear level", thr.mvpp, 32'h0000_03E8);
    check("irq masked", irq, 32'h0000_0000);
    check("rails follow", rx_out, 32'h0000_0000);
    check("tx follows", tx_out, 32'h0000_0003);
    c = 32'h0000_0000;
    c[RX_FILL_BIT] = 1'h1;
    c[TX_FILL_BIT] = 1'h1;
    wr(CTRL_OFFSET, c);
    repeat (20) @(posedge aclk);
    check("rx fill", ^rx_out, 32'h0000_0001);
    check("tx fill", ^tx_out, 32'h0000_0001);
    // five bus edges cover sync delay even if an edge races the pin
    repeat (2)
    begin
      @(posedge pins.mclk);
      repeat (5) @(posedge aclk);
      check("rx fill clock high", rx_clk, 32'h0000_0001);
      @(negedge pins.mclk);
      repeat (5) @(posedge aclk);
      check("rx fill clock low", rx_clk, 32'h0000_0000);
    end
    ticks(40, 1'h1, 11'h384);
    check("hysteresis", loss, 32'h0000_0001);
    ticks(32, 1'h1, 11'h5DC);
    check("cleared", loss, 32'h0000_0000);
    check("tx fill off", tx_out, 32'h0000_0003);
    $display("test fixed threshold and fill done");
    c = 32'h0000_0000;
    c[EQ_BIT] = 1'h1;
    c[LEVEL_LSB +: 5] = 5'h03;
    wr(CTRL_OFFSET, c);
    check("eq mode", thr.fixed, 32'h0000_0000);
    check("code 3", thr.atten_db, 32'h0000_000A);
    c[LEVEL_LSB +: 5] = 5'h1F;
    wr(CTRL_OFFSET, c);
    check("code clamp", thr.atten_db, 32'h0000_0018);
    @(posedge aclk);
    hw_req <= 1'h1;
    repeat (8) @(posedge aclk);
    check("hw fixed", thr.fixed, 32'h0000_0001);
    hw_req <= 1'h0;
    ticks(32, 1'h0, 11'h01E);
    check("eq declared", loss, 32'h0000_0001);
    check("eq clear level", thr.atten_db, 32'h0000_0014);
    ticks(32, 1'h1, 11'h00A);
    check("eq cleared", loss, 32'h0000_0000);
    $display("test equalizer done");
    c = 32'h0000_0000;
    c[CDR_BIT] = 1'h1;
    c[CRIT_BIT] = 1'h1;
    wr(CTRL_OFFSET, c);
    ticks(1000, 1'h1, 11'h5DC);
    rd_reg(STATUS_OFFSET);
    check("alarm early", rd[AIS_STAT_BIT], 32'h0000_0000);
    ticks(40, 1'h1, 11'h5DC);
    rd_reg(STATUS_OFFSET);
    check("alarm set", rd[AIS_STAT_BIT], 32'h0000_0001);
    // drop recovery while the alarm stands, so the gating is seen
    c[CDR_BIT] = 1'h0;
    wr(CTRL_OFFSET, c);
    rd_reg(STATUS_OFFSET);
    check("alarm off", rd[AIS_STAT_BIT], 32'h0000_0000);
    c[CDR_BIT] = 1'h1;
    wr(CTRL_OFFSET, c);
    ticks(1030, 1'h1, 11'h5DC);
    rd_reg(STATUS_OFFSET);
    check("alarm set again", rd[AIS_STAT_BIT], 32'h0000_0001);
    ticks(1100, 1'h0, 11'h5DC);
    rd_reg(STATUS_OFFSET);
    check("alarm clear", rd[AIS_STAT_BIT], 32'h0000_0000);
    $display("test alarm done");
    final_report();
  end
endmodule
